//--- rtl/cvcfg_ov_timer.v
`include "cvcfg_map.vh"
module cvcfg_ov_timer #(
   parameter UNIT_CYC = `CVCFG_DELAY_UNIT_CYC
) (
   input wire clk_i,
   input wire resetn_i,
   input wire start_i,
   input wire clr_i,
   input wire [2:0] code_i,
   output wire busy_o,
   output wire done_o
);
   reg [23:0] cnt_q;
   reg busy_q;
   wire [23:0] unit_w;
   assign unit_w = UNIT_CYC[23:0];
   assign busy_o = busy_q;
   assign done_o = busy_q && (cnt_q == 24'h000001);
   // counts on the controller clock; cleared with the fault
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q <= 24'h000000;
         busy_q <= 1'b0;
      end else if (clr_i) begin
         cnt_q <= 24'h000000;
         busy_q <= 1'b0;
      end else if (start_i) begin
         cnt_q <= unit_w << code_i;
         busy_q <= 1'b1;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 24'h000001;
         busy_q <= (cnt_q != 24'h000001);
      end
   end
endmodule // cvcfg_ov_timer

//--- rtl/cvcfg_regfile.v
`include "cvcfg_map.vh"
module cvcfg_regfile (
   input wire clk_i,
   input wire resetn_i,
   input wire wr_i,
   input wire [3:0] wslot_i,
   input wire [15:0] wdata_i,
   input wire [3:0] rslot_i,
   output reg [15:0] rdata_o,
   output wire [16*`CVCFG_NSLOTS-1:0] flat_o
);
   reg [15:0] mem_q [0:`CVCFG_NSLOTS-1];
   integer i;
   genvar g;
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (i = 0; i < `CVCFG_NSLOTS; i = i + 1) begin
            mem_q[i] <= `CVCFG_RST_WORD;
         end
         mem_q[`CVCFG_SLOT_OV_REACT] <= `CVCFG_RST_OV_REACT;
         rdata_o <= 16'h0000;
      end else begin
         if (wr_i && wslot_i < `CVCFG_NSLOTS) begin
            // reaction is a byte: upper bits stay zero
            if (wslot_i == `CVCFG_SLOT_OV_REACT) begin
               mem_q[wslot_i] <= {8'h00, wdata_i[7:0]};
            end else begin
               mem_q[wslot_i] <= wdata_i;
            end
         end
         if (rslot_i < `CVCFG_NSLOTS) begin
            rdata_o <= mem_q[rslot_i];
         end else begin
            rdata_o <= 16'h0000;
         end
      end
   end
   generate
      for (g = 0; g < `CVCFG_NSLOTS; g = g + 1) begin : g_flat
         assign flat_o[16*g+15:16*g] = mem_q[g];
      end
   endgenerate
endmodule // cvcfg_regfile

//--- rtl/cvcfg_top.v
`include "cvcfg_map.vh"
module cvcfg_top #(
   parameter DELAY_UNIT_CYC = `CVCFG_DELAY_UNIT_CYC
) (
   input wire clk_i,
   input wire resetn_i,
   input wire cmd_valid_i,
   input wire cmd_write_i,
   input wire [7:0] cmd_code_i,
   input wire [15:0] cmd_wdata_i,
   output reg cmd_ack_o,
   output reg cmd_err_o,
   output wire [15:0] cmd_rdata_o,
   input wire [7:0] vout_mode_i,
   input wire [15:0] nominal_target_i,
   input wire margin_low_sel_i,
   input wire [15:0] vout_meas_i,
   input wire [15:0] vin_meas_i,
   input wire [15:0] iout_raw_i,
   input wire on_cmd_i,
   input wire clear_bit_i,
   input wire clear_faults_i,
   output reg [15:0] setpoint_o,
   output reg [2:0] vout_format_o,
   output reg [15:0] load_line_slope_o,
   output reg [15:0] loop_gain_o,
   output reg [15:0] monitor_scale_o,
   output reg [15:0] duty_max_pct_o,
   output reg [15:0] freq_khz_o,
   output reg [3:0] group_id_o,
   output reg [3:0] rail_count_o,
   output reg [3:0] phase_slot_o,
   output reg [15:0] iout_report_o,
   output reg conv_run_o,
   output wire output_enable_o,
   output reg ov_fault_o,
   output reg ov_latched_o,
   output wire [2:0] ov_state_o
);
   localparam ST_RUN = 3'd0;
   localparam ST_DELAY = 3'd1;
   localparam ST_WAIT = 3'd2;
   localparam ST_LATCH = 3'd3;
   localparam ST_HOLD = 3'd4;
   localparam integer RAMP_TICK_I = `CVCFG_RAMP_TICK_CYC;

   // command code to register slot
   function [3:0] slot_of;
      input [7:0] code;
      begin
         if (code == `CVCFG_CMD_MARGIN_LOW) slot_of = `CVCFG_SLOT_MARGIN_LOW;
         else if (code == `CVCFG_CMD_SLEW) slot_of = `CVCFG_SLOT_SLEW;
         else if (code == `CVCFG_CMD_LOAD_LINE) slot_of = `CVCFG_SLOT_LOAD_LINE;
         else if (code == `CVCFG_CMD_LOOP_GAIN) slot_of = `CVCFG_SLOT_LOOP_GAIN;
         else if (code == `CVCFG_CMD_MON_SCALE) slot_of = `CVCFG_SLOT_MON_SCALE;
         else if (code == `CVCFG_CMD_DUTY_MAX) slot_of = `CVCFG_SLOT_DUTY_MAX;
         else if (code == `CVCFG_CMD_FREQ) slot_of = `CVCFG_SLOT_FREQ;
         else if (code == `CVCFG_CMD_VIN_ON) slot_of = `CVCFG_SLOT_VIN_ON;
         else if (code == `CVCFG_CMD_VIN_OFF) slot_of = `CVCFG_SLOT_VIN_OFF;
         else if (code == `CVCFG_CMD_SPREAD) slot_of = `CVCFG_SLOT_SPREAD;
         else if (code == `CVCFG_CMD_IOUT_OFS) slot_of = `CVCFG_SLOT_IOUT_OFS;
         else if (code == `CVCFG_CMD_OV_LIMIT) slot_of = `CVCFG_SLOT_OV_LIMIT;
         else if (code == `CVCFG_CMD_OV_REACT) slot_of = `CVCFG_SLOT_OV_REACT;
         else slot_of = `CVCFG_SLOT_NONE;
      end
   endfunction

   // linear word to signed integer: 5-bit exponent, 11-bit mantissa
   function signed [31:0] lin_val;
      input [15:0] w;
      reg signed [31:0] m;
      reg signed [5:0] e;
      begin
         m = {{21{w[10]}}, w[10:0]};
         e = {w[15], w[15:11]};
         if (e[5]) begin
            lin_val = m >>> (-e);
         end else begin
            lin_val = m <<< e;
         end
      end
   endfunction

   // clamp a signed value into 16 unsigned bits
   function [15:0] sat16;
      input signed [31:0] v;
      begin
         if (v < 0) sat16 = 16'h0000;
         else if (v > 32'sd65535) sat16 = 16'hFFFF;
         else sat16 = v[15:0];
      end
   endfunction

   // command decode
   wire [16*`CVCFG_NSLOTS-1:0] regs_w;
   wire [3:0] cmd_slot_w;
   wire cmd_hit_w;
   wire reg_wr_w;
   assign cmd_slot_w = slot_of(cmd_code_i);
   assign cmd_hit_w = (cmd_slot_w != `CVCFG_SLOT_NONE);
   assign reg_wr_w = cmd_valid_i && cmd_write_i && cmd_hit_w;

   // command register storage
   cvcfg_regfile u_regs (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .wr_i(reg_wr_w),
      .wslot_i(cmd_slot_w),
      .wdata_i(cmd_wdata_i),
      .rslot_i(cmd_slot_w),
      .rdata_o(cmd_rdata_o),
      .flat_o(regs_w)
   );

   // register slots unpacked
   wire [15:0] margin_low_w = regs_w[16*`CVCFG_SLOT_MARGIN_LOW +: 16];
   wire [15:0] slew_w = regs_w[16*`CVCFG_SLOT_SLEW +: 16];
   wire [15:0] load_line_w = regs_w[16*`CVCFG_SLOT_LOAD_LINE +: 16];
   wire [15:0] loop_gain_w = regs_w[16*`CVCFG_SLOT_LOOP_GAIN +: 16];
   wire [15:0] mon_scale_w = regs_w[16*`CVCFG_SLOT_MON_SCALE +: 16];
   wire [15:0] duty_w = regs_w[16*`CVCFG_SLOT_DUTY_MAX +: 16];
   wire [15:0] freq_w = regs_w[16*`CVCFG_SLOT_FREQ +: 16];
   wire [15:0] vin_on_w = regs_w[16*`CVCFG_SLOT_VIN_ON +: 16];
   wire [15:0] vin_off_w = regs_w[16*`CVCFG_SLOT_VIN_OFF +: 16];
   wire [15:0] spread_w = regs_w[16*`CVCFG_SLOT_SPREAD +: 16];
   wire [15:0] iout_ofs_w = regs_w[16*`CVCFG_SLOT_IOUT_OFS +: 16];
   wire [15:0] ov_limit_w = regs_w[16*`CVCFG_SLOT_OV_LIMIT +: 16];
   wire [15:0] ov_react_w = regs_w[16*`CVCFG_SLOT_OV_REACT +: 16];
   // reaction fields
   wire [1:0] resp_w = ov_react_w[`CVCFG_RESP_HI:`CVCFG_RESP_LO];
   wire [2:0] retry_w = ov_react_w[`CVCFG_RETRY_HI:`CVCFG_RETRY_LO];
   wire [2:0] delay_w = ov_react_w[`CVCFG_DELAY_HI:`CVCFG_DELAY_LO];

   // command handshake: one-cycle ack with read data registered
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cmd_ack_o <= 1'b0;
         cmd_err_o <= 1'b0;
      end else begin
         cmd_ack_o <= cmd_valid_i;
         cmd_err_o <= cmd_valid_i && !cmd_hit_w;
      end
   end

   // static configuration outputs
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         vout_format_o <= 3'b000;
         load_line_slope_o <= 16'h0000;
         loop_gain_o <= 16'h0000;
         monitor_scale_o <= 16'h0000;
         duty_max_pct_o <= 16'h0000;
         freq_khz_o <= 16'h0000;
         group_id_o <= 4'h0;
         rail_count_o <= 4'h0;
         phase_slot_o <= 4'h0;
         iout_report_o <= 16'h0000;
      end else begin
         vout_format_o <= vout_mode_i[`CVCFG_MODE_HI:`CVCFG_MODE_LO];
         load_line_slope_o <= load_line_w;
         loop_gain_o <= loop_gain_w;
         monitor_scale_o <= mon_scale_w;
         duty_max_pct_o <= sat16(lin_val(duty_w));
         freq_khz_o <= sat16(lin_val(freq_w));
         group_id_o <= spread_w[`CVCFG_GROUP_HI:`CVCFG_GROUP_LO];
         rail_count_o <= spread_w[`CVCFG_COUNT_HI:`CVCFG_COUNT_LO];
         // position at or beyond the count wraps to phase zero, the sync driver's slot
         if (spread_w[`CVCFG_POS_HI:`CVCFG_POS_LO] < spread_w[`CVCFG_COUNT_HI:`CVCFG_COUNT_LO]) begin
            phase_slot_o <= spread_w[`CVCFG_POS_HI:`CVCFG_POS_LO];
         end else begin
            phase_slot_o <= 4'h0;
         end
         iout_report_o <= sat16(lin_val(iout_raw_i) + lin_val(iout_ofs_w));
      end
   end

   // setpoint ramp toward nominal or margin-low target
   reg [15:0] tick_q;
   wire [31:0] ramp_full_w = RAMP_TICK_I;
   wire [15:0] ramp_last_w = ramp_full_w[15:0] - 16'h0001;
   wire tick_w = (tick_q == ramp_last_w);
   wire [15:0] target_w = margin_low_sel_i ? margin_low_w : nominal_target_i;
   wire [15:0] step_raw_w = sat16(lin_val(slew_w));
   wire [15:0] step_w = (step_raw_w == 16'h0000) ? 16'h0001 : step_raw_w;
   wire [16:0] up_w = {1'b0, setpoint_o} + {1'b0, step_w};
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_q <= 16'h0000;
         setpoint_o <= 16'h0000;
      end else begin
         tick_q <= tick_w ? 16'h0000 : tick_q + 16'h0001;
         if (tick_w) begin
            if (setpoint_o < target_w) begin
               setpoint_o <= (up_w[15:0] > target_w || up_w[16]) ? target_w : up_w[15:0];
            end else if (setpoint_o > target_w) begin
               setpoint_o <= (setpoint_o - target_w < step_w) ? target_w : setpoint_o - step_w;
            end
         end
      end
   end

   // input voltage hysteresis
   wire signed [31:0] vin_w = lin_val(vin_meas_i);
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         conv_run_o <= 1'b0;
      end else if (!conv_run_o && vin_w >= lin_val(vin_on_w)) begin
         conv_run_o <= 1'b1;
      end else if (conv_run_o && vin_w <= lin_val(vin_off_w)) begin
         conv_run_o <= 1'b0;
      end
   end

   // overvoltage detect and response
   reg on_prev_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [2:0] tries_q;
   reg [2:0] tries_d;
   reg latched_d;
   reg tmr_start;
   reg fresh_latch;
   wire ov_now_w = (vout_meas_i > ov_limit_w);
   wire off_on_w = on_cmd_i && !on_prev_q;
   wire clear_w = clear_bit_i || clear_faults_i || off_on_w;
   wire tmr_done_w;
   wire tmr_busy_w;
   assign ov_state_o = state_q;

   // delay and retry interval timer
   cvcfg_ov_timer #(
      .UNIT_CYC(DELAY_UNIT_CYC)
   ) u_tmr (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(tmr_start),
      .clr_i(clear_w),
      .code_i(delay_w),
      .busy_o(tmr_busy_w),
      .done_o(tmr_done_w)
   );

   // fault response next state
   always @* begin
      state_d = state_q;
      tries_d = tries_q;
      latched_d = ov_latched_o;
      tmr_start = 1'b0;
      case (state_q)
         ST_RUN: begin
            if (ov_now_w) begin
               if (resp_w == `CVCFG_RESP_DELAY) begin
                  state_d = ST_DELAY;
                  tmr_start = 1'b1;
               end else if (resp_w == `CVCFG_RESP_DISABLE) begin
                  if (retry_w == `CVCFG_RETRY_NONE) begin
                     state_d = ST_LATCH;
                     latched_d = 1'b1;
                  end else if (retry_w != `CVCFG_RETRY_FOREVER && tries_q >= retry_w) begin
                     state_d = ST_LATCH;
                     latched_d = 1'b1;
                  end else begin
                     state_d = ST_WAIT;
                     tmr_start = 1'b1;
                  end
               end else if (resp_w == `CVCFG_RESP_HOLD) begin
                  state_d = ST_HOLD;
               end
            end
         end
         ST_DELAY: begin
            if (!ov_now_w) begin
               state_d = ST_RUN;
            end else if (tmr_done_w) begin
               if (retry_w == `CVCFG_RETRY_NONE ||
                   (retry_w != `CVCFG_RETRY_FOREVER && tries_q >= retry_w)) begin
                  state_d = ST_LATCH;
                  latched_d = 1'b1;
               end else begin
                  state_d = ST_WAIT;
                  tmr_start = 1'b1;
               end
            end
         end
         ST_WAIT: begin
            // a stopped timer also ends the interval, so the wait cannot hang
            if (tmr_done_w || !tmr_busy_w) begin
               state_d = ST_RUN;
               if (retry_w != `CVCFG_RETRY_FOREVER) begin
                  tries_d = tries_q + 3'd1;
               end
            end
         end
         ST_LATCH: begin
            state_d = ST_LATCH;
         end
         ST_HOLD: begin
            if (!ov_now_w) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
      // a latch-off raised in the same cycle as a clear survives it
      fresh_latch = latched_d && !ov_latched_o;
      if (clear_w && !fresh_latch) begin
         state_d = ST_RUN;
         tries_d = 3'd0;
         latched_d = 1'b0;
         tmr_start = 1'b0;
      end
   end

   // fault response registers
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_RUN;
         tries_q <= 3'd0;
         ov_latched_o <= 1'b0;
         ov_fault_o <= 1'b0;
         on_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tries_q <= tries_d;
         ov_latched_o <= latched_d;
         ov_fault_o <= ov_now_w;
         on_prev_q <= on_cmd_i;
      end
   end

   // response 00 and 01-delay keep the output running
   assign output_enable_o = on_cmd_i && conv_run_o &&
                            (state_q == ST_RUN || state_q == ST_DELAY) && !tmr_busy_w_wait(state_q);

   function tmr_busy_w_wait;
      input [2:0] st;
      begin
         tmr_busy_w_wait = (st == ST_WAIT);
      end
   endfunction
endmodule // cvcfg_top

//--- shared/cvcfg_map.vh
`ifndef CVCFG_MAP_VH
`define CVCFG_MAP_VH
`define CVCFG_CMD_MARGIN_LOW 8'h26
`define CVCFG_CMD_SLEW 8'h27
`define CVCFG_CMD_LOAD_LINE 8'h28
`define CVCFG_CMD_LOOP_GAIN 8'h29
`define CVCFG_CMD_MON_SCALE 8'h2A
`define CVCFG_CMD_DUTY_MAX 8'h32
`define CVCFG_CMD_FREQ 8'h33
`define CVCFG_CMD_VIN_ON 8'h35
`define CVCFG_CMD_VIN_OFF 8'h36
`define CVCFG_CMD_SPREAD 8'h37
`define CVCFG_CMD_IOUT_OFS 8'h39
`define CVCFG_CMD_OV_LIMIT 8'h40
`define CVCFG_CMD_OV_REACT 8'h41
`define CVCFG_SLOT_MARGIN_LOW 4'h0
`define CVCFG_SLOT_SLEW 4'h1
`define CVCFG_SLOT_LOAD_LINE 4'h2
`define CVCFG_SLOT_LOOP_GAIN 4'h3
`define CVCFG_SLOT_MON_SCALE 4'h4
`define CVCFG_SLOT_DUTY_MAX 4'h5
`define CVCFG_SLOT_FREQ 4'h6
`define CVCFG_SLOT_VIN_ON 4'h7
`define CVCFG_SLOT_VIN_OFF 4'h8
`define CVCFG_SLOT_SPREAD 4'h9
`define CVCFG_SLOT_IOUT_OFS 4'hA
`define CVCFG_SLOT_OV_LIMIT 4'hB
`define CVCFG_SLOT_OV_REACT 4'hC
`define CVCFG_SLOT_NONE 4'hF
`define CVCFG_NSLOTS 13
`define CVCFG_RST_WORD 16'h0000
`define CVCFG_RST_OV_REACT 16'h0080
`define CVCFG_GROUP_HI 11
`define CVCFG_GROUP_LO 8
`define CVCFG_COUNT_HI 7
`define CVCFG_COUNT_LO 4
`define CVCFG_POS_HI 3
`define CVCFG_POS_LO 0
`define CVCFG_RESP_HI 7
`define CVCFG_RESP_LO 6
`define CVCFG_RETRY_HI 5
`define CVCFG_RETRY_LO 3
`define CVCFG_DELAY_HI 2
`define CVCFG_DELAY_LO 0
`define CVCFG_MODE_HI 7
`define CVCFG_MODE_LO 5
`define CVCFG_RESP_IGNORE 2'b00
`define CVCFG_RESP_DELAY 2'b01
`define CVCFG_RESP_DISABLE 2'b10
`define CVCFG_RESP_HOLD 2'b11
`define CVCFG_RETRY_NONE 3'b000
`define CVCFG_RETRY_FOREVER 3'b111
`define CVCFG_FMT_LINEAR 3'b000
`define CVCFG_FMT_IDCODE 3'b001
`define CVCFG_FMT_DIRECT 3'b010
`define CVCFG_DELAY_UNIT_US 1000
`define CVCFG_CLK_MHZ 125
`define CVCFG_DELAY_UNIT_CYC (`CVCFG_DELAY_UNIT_US * `CVCFG_CLK_MHZ)
`define CVCFG_RAMP_TICK_US 1
`define CVCFG_RAMP_TICK_CYC (`CVCFG_RAMP_TICK_US * `CVCFG_CLK_MHZ)
`endif

//--- tb/converter_config_and_ov_fault_response_bench.sv
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module converter_config_and_ov_fault_response_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, resetn_i = 1'b0, margin_low_sel_i = 1'b0, on_cmd_i = 1'b1;
   logic clear_bit_i = 1'b0, clear_faults_i = 1'b0;
   logic [7:0] vout_mode_i = 8'h00;
   logic [15:0] nominal_target_i = 16'h0800, vout_meas_i = 16'h0000, vin_meas_i = 16'h0040, iout_raw_i = 16'h000A;
   wire cmd_valid_i, cmd_write_i, cmd_ack_o, cmd_err_o, conv_run_o, output_enable_o, ov_fault_o, ov_latched_o;
   wire [7:0] cmd_code_i;
   wire [15:0] cmd_wdata_i, cmd_rdata_o, setpoint_o, load_line_slope_o, loop_gain_o, monitor_scale_o;
   wire [15:0] duty_max_pct_o, freq_khz_o, iout_report_o;
   wire [3:0] group_id_o, rail_count_o, phase_slot_o;
   wire [2:0] vout_format_o, ov_state_o;
   int error_cnt = 0, cmp_count = 0;
   logic [17:0] expq[$];
   logic [17:0] exp_v;
   logic [31:0] seed = 32'h13D8;
   logic [15:0] vals[13];
   logic [7:0] codes[13] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h32, 8'h33,
      8'h35, 8'h36, 8'h37, 8'h39, 8'h40, 8'h41};
   always #4 clk_i = ~clk_i;
   cvcfg_host_model h (.clk_i, .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i), .cmd_code_o(cmd_code_i),
      .cmd_wdata_o(cmd_wdata_i));
   cvcfg_top #(.DELAY_UNIT_CYC(8)) dut (.clk_i, .resetn_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_wdata_i,
      .cmd_ack_o, .cmd_err_o, .cmd_rdata_o, .vout_mode_i, .nominal_target_i, .margin_low_sel_i, .vout_meas_i,
      .vin_meas_i, .iout_raw_i, .on_cmd_i, .clear_bit_i, .clear_faults_i, .setpoint_o, .vout_format_o,
      .load_line_slope_o, .loop_gain_o, .monitor_scale_o, .duty_max_pct_o, .freq_khz_o, .group_id_o,
      .rail_count_o, .phase_slot_o, .iout_report_o, .conv_run_o, .output_enable_o, .ov_fault_o, .ov_latched_o,
      .ov_state_o);
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic err = 1'b0);
      expq.push_back({1'b0, err, 16'h0000});
      h.xfer(1'b1, c, d);
   endtask
   task automatic rd(input logic [7:0] c, input logic [16:0] e);
      expq.push_back({1'b1, e});
      h.xfer(1'b0, c, 16'h0000);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // fault under reaction r, check after n cycles, then clear by method how
   task automatic ovc(input logic [7:0] r, input int n, input logic [3:0] e, input logic cs, input int how);
      wr(8'h41, {8'h00, r});
      vout_meas_i = 16'h1001;
      tick(n);
      `CHK("latch flag", e[3], ov_latched_o)
      if (cs) `CHK("fault state", e[2:0], ov_state_o)
      if (cs) `CHK("output on", e[2:0] <= 3'd1, output_enable_o)
      vout_meas_i = 16'h0F00;
      clear_bit_i = (how == 0);
      clear_faults_i = (how == 1);
      on_cmd_i = (how != 2);
      tick(1);
      {clear_bit_i, clear_faults_i, on_cmd_i} = 3'b001;
      tick(2);
      `CHK("cleared state", 4'h0, {ov_latched_o, ov_state_o})
      `CHK("output back", 1'b1, output_enable_o)
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // answer checker
   always @(posedge clk_i) begin
      if (cmd_ack_o === 1'b1) begin
         if (expq.size() == 0) begin
            `CHK("spare ack", 1'b0, 1'b1)
         end else begin
            exp_v = expq.pop_front();
            `CHK("error flag", exp_v[16], cmd_err_o)
            if (exp_v[17]) `CHK("read word", exp_v[15:0], cmd_rdata_o)
         end
      end
   end
   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      tick(5);
      resetn_i = 1'b1;
      for (int i = 0; i < 13; i++) rd(codes[i], {1'b0, codes[i] == 8'h41 ? 16'h0080 : 16'h0000});
      rd(8'h30, {1'b1, 16'h0000});
      wr(8'h31, 16'h1234, 1'b1);
      for (int i = 0; i < 13; i++) begin
         vals[i] = xs();
         if (i == 12) vals[i] &= 16'h00FF;
         wr(codes[i], vals[i]);
      end
      for (int i = 0; i < 13; i++) rd(codes[i], {1'b0, vals[i]});
      `CHK("slope", vals[2], load_line_slope_o)
      `CHK("gains", {vals[3], vals[4]}, {loop_gain_o, monitor_scale_o})
      `CHK("group and count", vals[9][11:4], {group_id_o, rail_count_o})
      expq.push_back(18'h00000);
      h.spread(4'h3, 4'h4, 4'h2, 1'b0);
      tick(3);
      `CHK("rail slot", 4'h2, phase_slot_o)
      expq.push_back(18'h00000);
      h.spread(4'h3, 4'h4, 4'h6, 1'b0);
      tick(3);
      `CHK("rail slot", 4'h0, phase_slot_o)
      for (int f = 0; f < 3; f++) begin
         vout_mode_i = {f[2:0], 5'h00};
         tick(3);
         `CHK("format", f[2:0], vout_format_o)
      end
      wr(8'h32, 16'h0050);
      wr(8'h33, 16'h08FA);
      wr(8'h39, 16'h0005);
      tick(3);
      `CHK("decoded", {16'd80, 16'd500, 16'd15}, {duty_max_pct_o, freq_khz_o, iout_report_o})
      wr(8'h35, 16'h0030);
      wr(8'h36, 16'h0028);
      tick(3);
      `CHK("run", 1'b1, conv_run_o)
      vin_meas_i = 16'h0020;
      tick(3);
      `CHK("run", 1'b0, conv_run_o)
      vin_meas_i = 16'h002C;
      tick(3);
      `CHK("run", 1'b0, conv_run_o)
      vin_meas_i = 16'h0040;
      tick(3);
      `CHK("run", 1'b1, conv_run_o)
      wr(8'h27, 16'h0100);
      wr(8'h26, 16'h0400);
      tick(1200);
      `CHK("setpoint", 16'h0800, setpoint_o)
      margin_low_sel_i = 1'b1;
      tick(300);
      `CHK("ramping", 1'b1, setpoint_o > 16'h0400)
      tick(500);
      `CHK("setpoint", 16'h0400, setpoint_o)
      wr(8'h41, 16'h0000);
      wr(8'h40, 16'h1000);
      vout_meas_i = 16'h1001;
      tick(2);
      `CHK("over", 1'b1, ov_fault_o)
      vout_meas_i = 16'h1000;
      tick(2);
      `CHK("over", 1'b0, ov_fault_o)
      ovc(8'h00, 40, 4'h0, 1'b1, 0);
      ovc(8'h80, 5, 4'hB, 1'b1, 0);
      ovc(8'h88, 30, 4'hB, 1'b1, 1);
      ovc(8'hB8, 60, 4'h0, 1'b0, 0);
      ovc(8'h49, 5, 4'h1, 1'b1, 1);
      ovc(8'hC0, 5, 4'h4, 1'b1, 0);
      ovc(8'h80, 5, 4'hB, 1'b1, 2);
      tick(5);
      `CHK("open answers", 0, expq.size())
      print_verdict();
   end
endmodule // converter_config_and_ov_fault_response_bench

//--- tb/cvcfg_host_model.sv
module cvcfg_host_model (
   input wire clk_i,
   output logic cmd_valid_o,
   output logic cmd_write_o,
   output logic [7:0] cmd_code_o,
   output logic [15:0] cmd_wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_valid_o = 1'b0;
      cmd_write_o = 1'b0;
      cmd_code_o = 8'h00;
      cmd_wdata_o = 16'h0000;
   end
   // one-cycle command, then fields scrambled
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(posedge clk_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_write_o = w;
      cmd_code_o = c;
      cmd_wdata_o = d;
      @(posedge clk_i);
      #1;
      cmd_valid_o = 1'b0;
      cmd_code_o = ~c;
      cmd_wdata_o = ~d;
   endtask
   task automatic spread(input logic [3:0] g, input logic [3:0] n, input logic [3:0] p, input logic sync);
      xfer(1'b1, 8'h37, {4'h0, g, n, sync ? 4'h0 : p});
   endtask
endmodule // cvcfg_host_model

//--- tb/cvcfg_top_assertions.sv
module cvcfg_checker #(
   parameter int DELAY_UNIT_CYC = 8
) (
   input wire clk_i,
   input wire resetn_i,
   input wire cmd_valid_i,
   input wire cmd_write_i,
   input wire [7:0] cmd_code_i,
   input wire [15:0] cmd_wdata_i,
   input wire [15:0] vout_meas_i,
   input wire on_cmd_i,
   input wire clear_bit_i,
   input wire clear_faults_i,
   input wire [3:0] group_id_o,
   input wire [3:0] rail_count_o,
   input wire output_enable_o,
   input wire ov_fault_o,
   input wire ov_latched_o,
   input wire [2:0] ov_state_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic [15:0] lim_q, spr_q;
   logic [7:0] rea_q;
   logic on_q;
   int wcnt_q;
   wire wr = cmd_valid_i & cmd_write_i;
   wire over = vout_meas_i > lim_q;
   wire clr = clear_bit_i | clear_faults_i | (on_cmd_i & ~on_q);
   // shadow of limit, spread and reaction words, wait-state length
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lim_q <= 16'h0000;
         spr_q <= 16'h0000;
         rea_q <= 8'h80;
         on_q <= 1'b0;
         wcnt_q <= 0;
      end else begin
         if (wr && cmd_code_i == 8'h40) lim_q <= cmd_wdata_i;
         if (wr && cmd_code_i == 8'h37) spr_q <= cmd_wdata_i;
         if (wr && cmd_code_i == 8'h41) rea_q <= cmd_wdata_i[7:0];
         on_q <= on_cmd_i;
         wcnt_q <= (ov_state_o == 3'd2) ? wcnt_q + 1 : 0;
      end
   end
   sequence s_trip(logic [1:0] rc);
      rea_q[7:6] == rc && ov_state_o == 3'd0 && over && !clr;
   endsequence
   sequence s_no_retry;
      rea_q[5:3] == 3'b000;
   endsequence
   chk_group_field: assert property (wr && cmd_code_i == 8'h37 |=> ##[0:2] group_id_o == spr_q[11:8])
      else $error("group id differs from spread word");
   chk_rail_count: assert property (wr && cmd_code_i == 8'h37 |=> ##[0:2] rail_count_o == spr_q[7:4])
      else $error("rail count differs from spread word");
   chk_ignore_mode: assert property (rea_q[7:6] == 2'b00 && ov_state_o == 3'd0 |=> ov_state_o == 3'd0)
      else $error("state left run in ignore mode");
   chk_delay_entry: assert property (s_trip(2'b01) |=> ov_state_o == 3'd1)
      else $error("delay state not entered");
   chk_disable_now: assert property (s_trip(2'b10) |=> ov_fault_o && !output_enable_o &&
      ov_state_o inside {3'd2, 3'd3})
      else $error("output not disabled on fault");
   chk_no_retry: assert property (s_trip(2'b10) ##0 s_no_retry |=> ov_state_o == 3'd3 && ov_latched_o)
      else $error("no latch with zero retries");
   chk_hold_state: assert property (s_trip(2'b11) |=> ov_state_o == 3'd4 && !output_enable_o)
      else $error("hold state not entered");
   chk_hold_release: assert property (ov_state_o == 3'd4 && !over |=> ov_state_o == 3'd0)
      else $error("hold not released");
   chk_wait_span: assert property (ov_state_o != 3'd2 && $past(ov_state_o) == 3'd2 && !$past(clr)
      |-> wcnt_q == (DELAY_UNIT_CYC << rea_q[2:0]))
      else $error("wait interval length wrong");
   chk_latch_clear: assert property (ov_latched_o && clr |=> !ov_latched_o && ov_state_o == 3'd0)
      else $error("latched fault not cleared");
   chk_latch_stays: assert property (ov_latched_o && !clr |=> ov_latched_o && !output_enable_o)
      else $error("latched fault released");
endmodule // cvcfg_checker

bind cvcfg_top cvcfg_checker #(.DELAY_UNIT_CYC(DELAY_UNIT_CYC)) u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
   .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
   .vout_meas_i(vout_meas_i), .on_cmd_i(on_cmd_i), .clear_bit_i(clear_bit_i), .clear_faults_i(clear_faults_i),
   .group_id_o(group_id_o), .rail_count_o(rail_count_o), .output_enable_o(output_enable_o),
   .ov_fault_o(ov_fault_o), .ov_latched_o(ov_latched_o), .ov_state_o(ov_state_o));
